// [core/mci_interlock.sv]
// memory access stage interlock against a busy multiplier and instruction fetch
// assumes ma_req stays stable from its first valid cycle until ma_done is seen
`timescale 1ns/1ps

// What this block does
// - accumulator-to-register store stretches until multiplier free
// - accumulator store access splits slot with fetch
// - accumulator-to-memory store reads multiplier and writes memory
// - register-to-accumulator load stretches until multiplier free
// - memory-to-accumulator load uses memory and multiplier
// - accumulator load access splits slot with fetch
// - short multiply runs fetch, decode, execute, access, busy
// - short multiply keeps multiplier busy three cycles
// - short multiply access splits slot with fetch
// - non-multiplier follower sees no extra stall
// - multiplier-using follower gets contention handling
// - short accumulate second access stretches while busy
// - free multiplier after gap means no stall
// - signed and unsigned short multiply handled alike
module mci_interlock
   import mci_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        nrst,
   input  wire mci_ma_req_t ma_req,
   input  wire logic        if_req,
   output logic             hold_ff,
   output logic             fetch_grant_ff,
   output logic             mem_grant_ff,
   output logic             mul_grant_ff,
   output logic             ma_done_ff,
   output logic             mul_busy_ff
);

   typedef enum logic [1:0] {
      st_idle,
      st_wait,
      st_fetch,
      st_access
   } mci_state_t;

   mci_state_t           state_ff;
   mci_state_t           nxt_state;
   mci_op_t              op_ff;
   mci_op_t              nxt_op;
   mci_ctl_t             nxt_ctl;
   logic [MCI_CNT_W-1:0] busy_cnt;
   logic                 cnt_load;
   logic [MCI_CNT_W-1:0] cnt_val;
   logic                 free_next;
   logic                 cur_mul;
   logic                 cur_bus;

   // ==========================================================
   // instruction class decode
   function automatic logic uses_mul(input mci_op_t op);
      return !(op inside {op_other, op_mem});
   endfunction : uses_mul

   function automatic logic uses_bus(input mci_op_t op);
      return (op != op_other);
   endfunction : uses_bus

   function automatic logic uses_mem(input mci_op_t op);
      return op inside {op_mem, long_mul_accumulate, short_mul_accumulate,
                        store_accum_to_memory, load_accum_from_memory};
   endfunction : uses_mem

   // ==========================================================
   // multiplier busy tracking
   // both short multiplies share one busy load
   // busy three cycles after access ends, four after a long accumulate
   assign cnt_load = (state_ff == st_access) && uses_mul(op_ff) &&
                     (op_ff inside {long_mul_accumulate, short_mul_accumulate,
                                    signed_short_multiply, unsigned_short_multiply});
   assign cnt_val  = (op_ff == long_mul_accumulate) ? MCI_LONG_BUSY_CYC : MCI_SHORT_BUSY_CYC;

   mci_busy_cnt #(
      .W (MCI_CNT_W)
   ) u_busy (
      .core_clk (core_clk),
      .nrst     (nrst),
      .load     (cnt_load),
      .load_val (cnt_val),
      .cnt      (busy_cnt),
      .busy_ff  (mul_busy_ff)
   );

   // multiplier is free from the next cycle on
   assign free_next = (busy_cnt <= MCI_CNT_ONE);
   assign cur_mul   = uses_mul(nxt_op);
   assign cur_bus   = uses_bus(nxt_op);

   // ==========================================================
   // access stage sequencing
   always_comb begin
      nxt_state = state_ff;
      nxt_op    = op_ff;
      unique case (state_ff)
         st_idle: begin
            if (ma_req.valid) begin
               nxt_op = ma_req.op;
               if (uses_mul(ma_req.op) && !free_next) begin
                  nxt_state = st_wait;
               end else if (if_req && uses_bus(ma_req.op)) begin
                  nxt_state = st_fetch;
               end else begin
                  nxt_state = st_access;
               end
            end
         end
         st_wait: begin
            if (free_next) begin
               // split the stretched slot with fetch
               if (if_req) begin
                  nxt_state = st_fetch;
               end else begin
                  nxt_state = st_access;
               end
            end
         end
         st_fetch: begin
            nxt_state = st_access;
         end
         st_access: begin
            nxt_state = st_idle;
         end
      endcase
   end

   // ==========================================================
   // registered control outputs
   always_comb begin
      nxt_ctl = '0;
      // hold decode and execute while waiting
      nxt_ctl.hold        = (nxt_state == st_wait) || (nxt_state == st_fetch);
      nxt_ctl.fetch_grant = (nxt_state == st_fetch) ||
                            (if_req && !((nxt_state == st_access) && cur_bus) &&
                             (nxt_state != st_wait || !ma_req.valid));
      nxt_ctl.mem_grant   = (nxt_state == st_access) && uses_mem(nxt_op);
      nxt_ctl.mul_grant   = (nxt_state == st_access) && cur_mul;
      nxt_ctl.ma_done     = (nxt_state == st_access);
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff <= st_idle;
         op_ff    <= op_other;
      end else begin
         state_ff <= nxt_state;
         op_ff    <= nxt_op;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         hold_ff        <= 1'b0;
         fetch_grant_ff <= 1'b0;
         mem_grant_ff   <= 1'b0;
         mul_grant_ff   <= 1'b0;
         ma_done_ff     <= 1'b0;
      end else begin
         hold_ff        <= nxt_ctl.hold;
         fetch_grant_ff <= nxt_ctl.fetch_grant;
         mem_grant_ff   <= nxt_ctl.mem_grant;
         mul_grant_ff   <= nxt_ctl.mul_grant;
         ma_done_ff     <= nxt_ctl.ma_done;
      end
   end

   // ==========================================================
   // checks
   // short busy length
   a_short_busy_len: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_ff == st_access && op_ff inside {signed_short_multiply, unsigned_short_multiply})
      |=> mul_busy_ff [*3] ##1 !mul_busy_ff)
      else $error("short multiply busy length wrong");

   a_no_busy_access: assert property (@(posedge core_clk) disable iff (!nrst)
      mul_grant_ff |-> !mul_busy_ff)
      else $error("multiplier accessed while busy");

   a_hold_in_wait: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_ff == st_wait) |-> hold_ff && !ma_done_ff)
      else $error("front not held while stretched");

   a_stretch_bound: assert property (@(posedge core_clk) disable iff (!nrst)
      $rose(state_ff == st_wait) |-> ##[1:6] ma_done_ff)
      else $error("stretched access never finished");

   a_split_order: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_ff == st_fetch) |-> fetch_grant_ff && !mem_grant_ff ##1 ma_done_ff)
      else $error("split slot order wrong");

   a_plain_no_stall: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_ff == st_idle && ma_req.valid && ma_req.op == op_other) |=> ma_done_ff && !hold_ff)
      else $error("plain instruction stalled");

   a_free_no_stall: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_ff == st_idle && ma_req.valid && busy_cnt == MCI_CNT_ZERO && !if_req)
      |=> ma_done_ff && !hold_ff)
      else $error("stall with free multiplier");

   a_store_mem_both: assert property (@(posedge core_clk) disable iff (!nrst)
      (ma_done_ff && op_ff == store_accum_to_memory) |-> mem_grant_ff && mul_grant_ff)
      else $error("memory store missing a grant");

   // fetch and a bus-using access never share a slot; an op_other access can
   a_bus_exclusive: assert property (@(posedge core_clk) disable iff (!nrst)
      ma_done_ff && uses_bus(op_ff) |-> !fetch_grant_ff)
      else $error("fetch and access overlap");

   // register load waits for busy end
   a_load_waits: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_ff == st_idle && ma_req.valid && ma_req.op == load_accum_from_register &&
       busy_cnt > MCI_CNT_ONE) |=> hold_ff && !ma_done_ff)
      else $error("register load did not wait");

   a_done_pulse: assert property (@(posedge core_clk) disable iff (!nrst)
      ma_done_ff |=> !ma_done_ff)
      else $error("done longer than one cycle");

   a_long_busy_len: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_ff == st_access && op_ff == long_mul_accumulate) |=> mul_busy_ff [*4] ##1 !mul_busy_ff)
      else $error("long accumulate busy length wrong");

   a_short_mac_busy: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_ff == st_access && op_ff == short_mul_accumulate) |=> mul_busy_ff [*3] ##1 !mul_busy_ff)
      else $error("short accumulate busy length wrong");

   a_load_mem_both: assert property (@(posedge core_clk) disable iff (!nrst)
      (ma_done_ff && op_ff == load_accum_from_memory) |-> mem_grant_ff && mul_grant_ff)
      else $error("memory load missing a grant");

   a_reg_no_mem: assert property (@(posedge core_clk) disable iff (!nrst)
      (ma_done_ff && op_ff inside {store_accum_to_register, load_accum_from_register})
      |-> !mem_grant_ff && mul_grant_ff)
      else $error("register accumulator move touched memory");

   a_grant_in_slot: assert property (@(posedge core_clk) disable iff (!nrst)
      (mem_grant_ff || mul_grant_ff) |-> ma_done_ff)
      else $error("grant outside the access slot");

   a_store_split: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_ff == st_wait && free_next && if_req &&
       op_ff inside {store_accum_to_register, store_accum_to_memory})
      |=> (fetch_grant_ff && hold_ff && !ma_done_ff) ##1 (ma_done_ff && !fetch_grant_ff))
      else $error("stretched store did not split with fetch");

   a_load_split: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_ff == st_wait && free_next && if_req &&
       op_ff inside {load_accum_from_register, load_accum_from_memory})
      |=> (fetch_grant_ff && hold_ff && !ma_done_ff) ##1 (ma_done_ff && !fetch_grant_ff))
      else $error("stretched load did not split with fetch");

   a_fetch_first: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_ff == st_idle && ma_req.valid && free_next && if_req &&
       ma_req.op inside {signed_short_multiply, unsigned_short_multiply})
      |=> (fetch_grant_ff && hold_ff) ##1 (ma_done_ff && mul_grant_ff))
      else $error("short multiply did not yield to fetch");

   a_short_stages: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_ff == st_idle && ma_req.valid && free_next && !if_req &&
       ma_req.op inside {signed_short_multiply, unsigned_short_multiply})
      |=> ma_done_ff && mul_grant_ff && !mem_grant_ff && !hold_ff)
      else $error("short multiply access not in one slot");

   a_hold_released: assert property (@(posedge core_clk) disable iff (!nrst)
      ma_done_ff |-> !hold_ff)
      else $error("front still held in access slot");

   a_busy_blocks: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_ff == st_idle && ma_req.valid && uses_mul(ma_req.op) && !free_next)
      |=> hold_ff && !ma_done_ff)
      else $error("multiplier user not stretched while busy");

endmodule : mci_interlock

// [core/mci_pkg.sv]
// shared types and constants of the multiplier contention interlock
// assumes one core clock; the pipeline holds the memory-access request stable until done
package mci_pkg;

   // ==========================================================
   // counter and timing constants
   localparam int          MCI_CNT_W          = 3;
   localparam logic [2:0]  MCI_CNT_ZERO       = 3'h0;
   localparam logic [2:0]  MCI_CNT_ONE        = 3'h1;
   // multiplier busy cycles after the access of a short multiply
   localparam logic [2:0]  MCI_SHORT_BUSY_CYC = 3'h3;
   // multiplier busy cycles after the last access of a long accumulate
   localparam logic [2:0]  MCI_LONG_BUSY_CYC  = 3'h4;

   // ==========================================================
   // instruction classes seen at the memory access stage
   typedef enum logic [3:0] {
      op_other,
      op_mem,
      long_mul_accumulate,
      short_mul_accumulate,
      signed_short_multiply,
      unsigned_short_multiply,
      store_accum_to_register,
      store_accum_to_memory,
      load_accum_from_register,
      load_accum_from_memory
   } mci_op_t;

   typedef struct packed {
      logic    valid;
      mci_op_t op;
   } mci_ma_req_t;

   typedef struct packed {
      logic hold;
      logic fetch_grant;
      logic mem_grant;
      logic mul_grant;
      logic ma_done;
   } mci_ctl_t;

endpackage : mci_pkg

// [core/mci_busy_cnt.sv]
// multiplier busy down-counter
// assumes load only while the counter is idle or on its last count
`timescale 1ns/1ps
module mci_busy_cnt
   import mci_pkg::*;
#(
   parameter int W = MCI_CNT_W
) (
   input  wire logic         core_clk,
   input  wire logic         nrst,
   input  wire logic         load,
   input  wire logic [W-1:0] load_val,
   output logic [W-1:0]      cnt,
   output logic              busy_ff
);

   logic [W-1:0] cnt_ff;
   logic [W-1:0] nxt_cnt;

   // ==========================================================
   // count down to zero
   always_comb begin
      if (load) begin
         nxt_cnt = load_val;
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - W'(1);
      end else begin
         nxt_cnt = cnt_ff;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         cnt_ff  <= '0;
         busy_ff <= 1'b0;
      end else begin
         cnt_ff  <= nxt_cnt;
         busy_ff <= (nxt_cnt != '0);
      end
   end

   assign cnt = cnt_ff;

endmodule : mci_busy_cnt

// [dv/mci_bus_model.sv]
// memory bus model shared by instruction fetch and the access stage
// assumes grants come from the interlock, sampled on core_clk
`timescale 1ns/1ps
module mci_bus_model (
   input  wire logic core_clk,
   input  wire logic nrst,
   input  wire logic fetch_want,
   input  wire logic fetch_grant,
   input  wire logic mem_grant,
   output logic      if_req,
   output logic      clash_ff
);
   // =========
   // fetch side wants the bus
   assign if_req = fetch_want;

   // =========
   // bus ownership
   // one owner per slot
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         clash_ff <= 1'b0;
      end else if (fetch_grant && mem_grant) begin
         clash_ff <= 1'b1;
      end
   end
endmodule : mci_bus_model

// [dv/tb_multiplier_contention_interlock.sv]
// self-checking bench of the multiplier contention interlock
// assumes inputs driven 1 ns after each rising edge of core_clk
`timescale 1ns/1ps
module tb_multiplier_contention_interlock;
   import mci_pkg::*;
   logic        core_clk   = 1'b0;
   logic        nrst       = 1'b0;
   mci_ma_req_t ma_req     = '0;
   logic        fetch_want = 1'b0;
   logic        if_req;
   logic        hold_ff;
   logic        fetch_grant_ff;
   logic        mem_grant_ff;
   logic        mul_grant_ff;
   logic        ma_done_ff;
   logic        mul_busy_ff;
   logic        clash_ff;
   int          num_errors = 0;
   int          checks     = 0;

   always #2.5 core_clk = ~core_clk;

   mci_interlock i_dut (.core_clk(core_clk), .nrst(nrst), .ma_req(ma_req), .if_req(if_req),
      .hold_ff(hold_ff), .fetch_grant_ff(fetch_grant_ff), .mem_grant_ff(mem_grant_ff),
      .mul_grant_ff(mul_grant_ff), .ma_done_ff(ma_done_ff), .mul_busy_ff(mul_busy_ff));
   mci_bus_model i_bus (.core_clk(core_clk), .nrst(nrst), .fetch_want(fetch_want),
      .fetch_grant(fetch_grant_ff), .mem_grant(mem_grant_ff), .if_req(if_req), .clash_ff(clash_ff));

   // =========
   // compares and verdict
   task automatic chk_bit(input logic got, input logic exp, input string msg);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %b expected %b", $time, msg, got, exp);
      end
   endtask : chk_bit

   task automatic chk_cnt(input logic [3:0] got, input logic [3:0] exp, input string msg);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: %s got %0d expected %0d", $time, msg, got, exp);
      end
   endtask : chk_cnt

   task automatic give_verdict();
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : give_verdict

   // =========
   // one access: present, wait for done, judge
   task automatic run(input mci_op_t op, input logic ifr, input logic [3:0] lat, input logic mem,
                      input logic mul);
      logic [3:0] n;
      logic       fg;
      logic       hd;
      n = 4'h0;
      fg = 1'b0;
      hd = 1'b0;
      ma_req = mci_ma_req_t'{1'b1, op};
      fetch_want = ifr;
      do begin
         fg = fetch_grant_ff;
         hd = hd | hold_ff;
         @(posedge core_clk);
         #1;
         n++;
      end while (n < 4'hA && ma_done_ff !== 1'b1);
      chk_cnt(n, lat, "latency");
      chk_bit(mem_grant_ff, mem, "memory grant");
      chk_bit(mul_grant_ff, mul, "multiplier grant");
      chk_bit(hd, lat > 4'h1, "hold");
      if (ifr) chk_bit(fg, 1'b1, "fetch first");
      @(posedge core_clk);
      #1;
   endtask : run

   task automatic idle();
      ma_req = '0;
      fetch_want = 1'b0;
      repeat (6) @(posedge core_clk);
      #1;
   endtask : idle

   // =========
   // scenarios
   task automatic t_reset();
      chk_bit(ma_done_ff | hold_ff | mul_busy_ff | mul_grant_ff | fetch_grant_ff | mem_grant_ff, 1'b0,
              "after reset");
   endtask : t_reset

   task automatic t_short_mul();
      mci_op_t ops [2];
      ops = '{signed_short_multiply, unsigned_short_multiply};
      foreach (ops[k]) begin
         run(ops[k], 1'b0, 4'h1, 1'b0, 1'b1);
         ma_req = '0;
         for (int i = 0; i < 4; i++) begin
            chk_bit(mul_busy_ff, i < 3, "multiplier busy");
            @(posedge core_clk);
            #1;
         end
      end
   endtask : t_short_mul

   task automatic t_follow_store();
      run(signed_short_multiply, 1'b0, 4'h1, 1'b0, 1'b1);
      run(store_accum_to_register, 1'b1, 4'h4, 1'b0, 1'b1);
      idle();
      run(long_mul_accumulate, 1'b0, 4'h1, 1'b1, 1'b1);
      run(store_accum_to_memory, 1'b0, 4'h4, 1'b1, 1'b1);
      idle();
   endtask : t_follow_store

   task automatic t_follow_load();
      run(long_mul_accumulate, 1'b0, 4'h1, 1'b1, 1'b1);
      run(load_accum_from_register, 1'b0, 4'h4, 1'b0, 1'b1);
      idle();
      run(unsigned_short_multiply, 1'b0, 4'h1, 1'b0, 1'b1);
      run(load_accum_from_memory, 1'b1, 4'h4, 1'b1, 1'b1);
      idle();
   endtask : t_follow_load

   task automatic t_short_mac();
      run(signed_short_multiply, 1'b0, 4'h1, 1'b0, 1'b1);
      run(short_mul_accumulate, 1'b0, 4'h3, 1'b1, 1'b1);
      idle();
      run(unsigned_short_multiply, 1'b0, 4'h1, 1'b0, 1'b1);
      run(op_other, 1'b0, 4'h1, 1'b0, 1'b0);
      run(short_mul_accumulate, 1'b0, 4'h1, 1'b1, 1'b1);
      run(signed_short_multiply, 1'b0, 4'h3, 1'b0, 1'b1);
      idle();
   endtask : t_short_mac

   task automatic t_mid_reset();
      run(long_mul_accumulate, 1'b0, 4'h1, 1'b1, 1'b1);
      ma_req = '0;
      nrst = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      chk_bit(ma_done_ff | hold_ff | mul_busy_ff | fetch_grant_ff, 1'b0, "in reset");
      nrst = 1'b1;
      run(store_accum_to_register, 1'b0, 4'h1, 1'b0, 1'b1);
      idle();
   endtask : t_mid_reset

   task automatic t_split();
      run(op_mem, 1'b1, 4'h2, 1'b1, 1'b0);
      idle();
      run(unsigned_short_multiply, 1'b1, 4'h2, 1'b0, 1'b1);
      idle();
      chk_bit(clash_ff, 1'b0, "bus clash");
   endtask : t_split

   initial begin
      repeat (10) @(posedge core_clk);
      #1;
      nrst = 1'b1;
      t_reset();
      t_short_mul();
      t_follow_store();
      t_follow_load();
      t_short_mac();
      t_split();
      t_mid_reset();
      give_verdict();
   end

   initial begin
      #20000;
      num_errors++;
      give_verdict();
   end
endmodule : tb_multiplier_contention_interlock
